// file: logic/ogb_gearbox.sv
// output serializer gearbox: parallel core words to one serial pin
//
// Overview of operation
// - core word lanes follow mode and cell
// - word bits leave one by one on q
// - stage one captures core word on clock
// - stage two hands word to edge stage
// - stage three shifts bits out per edge
// - two edge clocks offered, one selected
// - modes seven, eight, or four bits wide
`timescale 1ns/1ps
module ogb_gearbox
    import ogb_pkg::*;
(
    // clock and reset
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst,
    // configuration
    input  wire ogb_mode_t        i_mode,
    input  wire logic             i_third_cell,
    input  wire logic             i_edge_sel,
    // edge clocks, sampled on the system clock
    input  wire logic [1:0]       i_fast_edge_clocks,
    // parallel words from the core
    input  wire logic             i_data_valid,
    input  wire logic [7:0]       i_data,
    output logic                  o_data_ready,
    // serial output toward the pin buffer
    output logic                  o_q,
    output logic                  o_q_active
);

    ogb_stream_if #(.W(OGB_WORD_W)) word_s ();

    ogb_core_t  core_reg;
    ogb_core_t  core_next;
    logic       edge_now;
    logic       edge_seen;
    logic       consume;
    logic       load;
    logic [7:0] word_cut;
    logic [3:0] word_len;

    // stage one: capture core words, back-pressure via ready
    ogb_pair_buf #(
        .W          (OGB_WORD_W)
    ) u_stage1 (
        .i_clk_sys  (i_clk_sys),
        .i_rst      (i_rst),
        .i_valid    (i_data_valid),
        .i_data     (i_data),
        .o_ready    (o_data_ready),
        .out        (word_s)
    );

    // select lanes of the core word for the current mode
    always_comb
    begin
        word_cut = OGB_WORD_RST;
        word_len = OGB_LEN_EIGHT;
        unique case (i_mode)
            OGB_MODE_SEVEN:
            begin
                word_cut[OGB_SEVEN_MSB:0] = word_s.data[OGB_SEVEN_MSB:0];
                word_len                  = OGB_LEN_SEVEN;
            end
            OGB_MODE_EIGHT:
            begin
                word_cut = word_s.data;
                word_len = OGB_LEN_EIGHT;
            end
            OGB_MODE_FOUR:
            begin
                if (i_third_cell)
                begin
                    word_cut[OGB_NIB_W-1:0] = word_s.data[OGB_NIB_HI_LSB +: OGB_NIB_W];
                end
                else
                begin
                    word_cut[OGB_NIB_W-1:0] = word_s.data[OGB_NIB_LO_LSB +: OGB_NIB_W];
                end
                word_len = OGB_LEN_FOUR;
            end
            default:
            begin
                word_cut = OGB_WORD_RST;
                word_len = OGB_LEN_EIGHT;
            end
        endcase
    end

    // edge of the chosen edge clock, both polarities count
    assign edge_now  = i_fast_edge_clocks[i_edge_sel];
    assign edge_seen = edge_now ^ core_reg.edge_prev;
    assign consume   = edge_seen && (core_reg.cnt == 4'h0) && core_reg.xfer_valid;
    assign load      = !core_reg.xfer_valid || consume;
    assign word_s.ready = load;

    // stages two and three
    always_comb
    begin
        core_next           = core_reg;
        core_next.edge_prev = edge_now;
        // stage three: one bit per edge, lsb first
        if (edge_seen)
        begin
            if (core_reg.cnt != 4'h0)
            begin
                core_next.q        = core_reg.shift[0];
                core_next.shift    = {1'b0, core_reg.shift[7:1]};
                core_next.cnt      = core_reg.cnt - 4'h1;
                core_next.q_active = 1'b1;
            end
            else if (core_reg.xfer_valid)
            begin
                core_next.q        = core_reg.xfer[0];
                core_next.shift    = {1'b0, core_reg.xfer[7:1]};
                core_next.cnt      = core_reg.xfer_len - 4'h1;
                core_next.q_active = 1'b1;
            end
            else
            begin
                core_next.q        = OGB_IDLE_LEVEL; // underrun: line idles
                core_next.q_active = 1'b0;
            end
        end
        // stage two: take next word when transfer register frees
        if (load)
        begin
            core_next.xfer_valid = word_s.valid;
            if (word_s.valid)
            begin
                core_next.xfer     = word_cut;
                core_next.xfer_len = word_len;
            end
        end
    end

    // state register
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            core_reg <= OGB_CORE_RST;
        end
        else
        begin
            core_reg <= core_next;
        end
    end

    // outputs straight from flops
    assign o_q        = core_reg.q;
    assign o_q_active = core_reg.q_active;

endmodule : ogb_gearbox

// file: logic/ogb_pkg.sv
// shared constants and types of the output serializer gearbox
package ogb_pkg;

    // parallel word from the core
    localparam int unsigned OGB_WORD_W       = 8;
    localparam int unsigned OGB_LEN_W        = 4;
    localparam int unsigned OGB_BUF_DEPTH    = 2;

    // bits sent per word in each mode
    localparam logic [3:0]  OGB_LEN_SEVEN    = 4'h7;
    localparam logic [3:0]  OGB_LEN_EIGHT    = 4'h8;
    localparam logic [3:0]  OGB_LEN_FOUR     = 4'h4;

    // field positions inside the parallel word
    localparam int unsigned OGB_SEVEN_MSB    = 6;
    localparam int unsigned OGB_NIB_LO_LSB   = 0;
    localparam int unsigned OGB_NIB_HI_LSB   = 4;
    localparam int unsigned OGB_NIB_W        = 4;

    // serial line level while nothing is sent
    localparam logic        OGB_IDLE_LEVEL   = 1'b0;
    localparam logic [7:0]  OGB_WORD_RST     = 8'h00;

    // gearbox ratio
    typedef enum logic [1:0] {
        OGB_MODE_SEVEN,
        OGB_MODE_EIGHT,
        OGB_MODE_FOUR
    } ogb_mode_t;

    // state of the transfer and shift stages
    typedef struct packed {
        logic [7:0] xfer;
        logic       xfer_valid;
        logic [3:0] xfer_len;
        logic [7:0] shift;
        logic [3:0] cnt;
        logic       edge_prev;
        logic       q;
        logic       q_active;
    } ogb_core_t;

    localparam ogb_core_t OGB_CORE_RST = '{
        xfer:       OGB_WORD_RST,
        xfer_valid: 1'b0,
        xfer_len:   4'h0,
        shift:      OGB_WORD_RST,
        cnt:        4'h0,
        edge_prev:  1'b0,
        q:          OGB_IDLE_LEVEL,
        q_active:   1'b0
    };

endpackage : ogb_pkg

// file: logic/ogb_stream_if.sv
// word stream between the input buffer and the transfer stage
`timescale 1ns/1ps
interface ogb_stream_if #(
    parameter int unsigned W = 8
);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : ogb_stream_if

// file: logic/ogb_pair_buf.sv
// two-entry word buffer with valid and ready on both sides
`timescale 1ns/1ps
module ogb_pair_buf
    import ogb_pkg::*;
#(
    parameter int unsigned W = OGB_WORD_W
) (
    // clock and reset
    input  wire logic         i_clk_sys,
    input  wire logic         i_rst,
    // filling side
    input  wire logic         i_valid,
    input  wire logic [W-1:0] i_data,
    output logic              o_ready,
    // draining side
    ogb_stream_if.src         out
);

    typedef struct packed {
        logic [1:0][W-1:0] mem;
        logic              wr;
        logic              rd;
        logic [1:0]        count;
        logic              in_ready;
    } ogb_buf_state_t;

    ogb_buf_state_t st_reg;
    ogb_buf_state_t st_next;
    logic           push;
    logic           pop;

    // head entry and fill handshake
    assign out.valid = (st_reg.count != 2'h0);
    assign out.data  = st_reg.mem[st_reg.rd];
    assign o_ready   = st_reg.in_ready;
    assign push      = i_valid && st_reg.in_ready;
    assign pop       = out.valid && out.ready;

    // pointer and count update
    always_comb
    begin
        st_next = st_reg;
        if (push)
        begin
            st_next.mem[st_reg.wr] = i_data;
            st_next.wr             = ~st_reg.wr;
        end
        if (pop)
        begin
            st_next.rd = ~st_reg.rd;
        end
        st_next.count    = st_reg.count + {1'b0, push} - {1'b0, pop};
        st_next.in_ready = (st_next.count != 2'(OGB_BUF_DEPTH)); // stall when full
    end

    // state register
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            st_reg <= '{mem: '0, wr: 1'b0, rd: 1'b0, count: 2'h0, in_ready: 1'b0};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

endmodule : ogb_pair_buf

// file: sim/ogb_monitor.sv
// port checker of the gearbox
`timescale 1ns/1ps
module ogb_monitor
    import ogb_pkg::*;
(
    input wire logic       i_clk_sys,
    input wire logic       i_rst,
    input wire ogb_mode_t  i_mode,
    input wire logic       i_third_cell,
    input wire logic       i_edge_sel,
    input wire logic [1:0] i_fast_edge_clocks,
    input wire logic       i_data_valid,
    input wire logic [7:0] i_data,
    input wire logic       o_data_ready,
    input wire logic       o_q,
    input wire logic       o_q_active
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    logic prev_reg;
    logic ch;
    // sampled change of the selected edge clock
    assign ch = i_fast_edge_clocks[i_edge_sel] != prev_reg;
    always_ff @(posedge i_clk_sys)
        prev_reg <= i_rst ? 1'b0 : i_fast_edge_clocks[i_edge_sel];
    property p_idle; !o_q_active |-> !o_q; endproperty
    a_idle: assert property (p_idle) else $error("line not idle");
    property p_rst; $fell(i_rst) |-> !o_data_ready && !o_q_active; endproperty
    a_rst: assert property (p_rst) else $error("busy after reset");
    property p_rdy; $fell(i_rst) |=> o_data_ready; endproperty
    a_rdy: assert property (p_rdy) else $error("ready late");
    property p_hold; o_data_ready && !i_data_valid |=> o_data_ready; endproperty
    a_hold: assert property (p_hold) else $error("ready dropped");
    property p_step; $changed(o_q) |-> $past(ch); endproperty
    a_step: assert property (p_step) else $error("bit off edge");
    property p_rise; $rose(o_q_active) |-> $past(ch); endproperty
    a_rise: assert property (p_rise) else $error("start off edge");
    property p_sel; !ch ##1 !ch |-> $stable(o_q_active); endproperty
    a_sel: assert property (p_sel) else $error("step without edge");
    property p_flow; (i_data_valid && o_data_ready) ##1 ch [*4] |=> o_q_active; endproperty
    a_flow: assert property (p_flow) else $error("word not sent");
    c_take: cover property (i_data_valid && o_data_ready);
    c_full: cover property (i_data_valid && !o_data_ready);
    c_start: cover property ($rose(o_q_active));
endmodule : ogb_monitor
bind ogb_gearbox ogb_monitor ogb_monitor_inst (.i_clk_sys, .i_rst, .i_mode, .i_third_cell,
    .i_edge_sel, .i_fast_edge_clocks, .i_data_valid, .i_data, .o_data_ready, .o_q, .o_q_active);

// file: sim/ogb_core_model.sv
// core side model: offers words, makes edge clocks
`timescale 1ns/1ps
module ogb_core_model (
    input  wire logic       i_clk_sys,
    input  wire logic       i_ready,
    input  wire logic       i_run,
    input  wire logic       i_sel,
    output logic            o_valid = 1'b0,
    output logic [7:0]      o_data = 8'h00,
    output logic [1:0]      o_edges = 2'h0
);
    // selected edge clock toggles each cycle while running
    always @(posedge i_clk_sys)
        if (i_run) o_edges[i_sel] <= ~o_edges[i_sel];
    // offer a word, hold it until taken
    task automatic send(input logic [7:0] w);
        o_valid <= 1'b1;
        o_data  <= w;
        @(posedge i_clk_sys);
        while (!i_ready) @(posedge i_clk_sys);
    endtask : send
    // release: data shows the inverse of the last word
    task automatic stop();
        o_valid <= 1'b0;
        o_data  <= ~o_data;
    endtask : stop
endmodule : ogb_core_model

// file: sim/ogb_gearbox_tb_top.sv
// self-checking bench of the output gearbox
`timescale 1ns/1ps
module ogb_gearbox_tb_top;
    import ogb_pkg::*;
    logic       i_clk_sys = 1'b0;
    logic       i_rst = 1'b1;
    ogb_mode_t  i_mode = OGB_MODE_EIGHT;
    logic       i_third_cell = 1'b0;
    logic       i_edge_sel = 1'b0;
    logic       run = 1'b0;
    logic       v, rdy, q, qa;
    logic [7:0] d;
    logic [1:0] ec;
    logic       exp_q[$];
    int         err_count = 0;
    int         check_count = 0;
    int         cyc = 0;
    always #4 i_clk_sys = ~i_clk_sys;
    ogb_gearbox ogb_gearbox_inst (.i_clk_sys, .i_rst, .i_mode, .i_third_cell, .i_edge_sel,
        .i_fast_edge_clocks(ec), .i_data_valid(v), .i_data(d), .o_data_ready(rdy),
        .o_q(q), .o_q_active(qa));
    ogb_core_model ogb_core_model_inst (.i_clk_sys, .i_ready(rdy), .i_run(run),
        .i_sel(i_edge_sel), .o_valid(v), .o_data(d), .o_edges(ec));
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        check_count++;
        if (seen !== want)
        begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : print_verdict
    // every active line bit against the expected stream; hang guard
    always @(posedge i_clk_sys)
    begin
        cyc++;
        if (!i_rst && qa === 1'b1)
            check({7'h00, q}, {7'h00, (exp_q.size() ? exp_q.pop_front() : 1'bx)});
        if (cyc == 20000)
        begin
            err_count++;
            print_verdict();
        end
    end
    task automatic push(input logic [7:0] w, input int lo, input int n);
        for (int i = 0; i < n; i++) exp_q.push_back(w[lo+i]);
    endtask : push
    task automatic drain();
        for (int i = 0; i < 200 && exp_q.size() > 0; i++) @(posedge i_clk_sys);
        repeat (3) @(posedge i_clk_sys);
        check({7'h00, qa}, 8'h00);
        check(8'(exp_q.size()), 8'h00);
    endtask : drain
    // two back-to-back words in one mode and cell
    task automatic t_words(input ogb_mode_t m, input logic c, input logic [7:0] a,
        input logic [7:0] b, input int lo, input int n);
        i_mode <= m;
        i_third_cell <= c;
        @(posedge i_clk_sys);
        push(a, lo, n);
        push(b, lo, n);
        ogb_core_model_inst.send(a);
        ogb_core_model_inst.send(b);
        ogb_core_model_inst.stop();
        drain();
        $display("words test mode %0d done", m);
    endtask : t_words
    // line stalled: buffer fills and refuses, then drains in order
    task automatic t_stall();
        run <= 1'b0;
        i_mode <= OGB_MODE_EIGHT;
        fork
        begin
            repeat (40) @(posedge i_clk_sys);
            check({7'h00, rdy}, 8'h00);
            run <= 1'b1;
        end
        join_none
        for (int i = 0; i < 5; i++) push(8'h40 | 8'(i), 0, 8);
        for (int i = 0; i < 5; i++) ogb_core_model_inst.send(8'h40 | 8'(i));
        ogb_core_model_inst.stop();
        drain();
        $display("stall test done");
    endtask : t_stall
    initial
    begin
        repeat (2) @(posedge i_clk_sys);
        check({5'h00, rdy, qa, q}, 8'h00);
        repeat (2) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        run <= 1'b1;
        repeat (3) @(posedge i_clk_sys);
        t_words(OGB_MODE_EIGHT, 1'b0, 8'hA5, 8'h3C, 0, 8);
        t_words(OGB_MODE_SEVEN, 1'b0, 8'hFF, 8'h2A, 0, 7);
        t_words(OGB_MODE_FOUR, 1'b0, 8'h5A, 8'hC3, 0, 4);
        t_words(OGB_MODE_FOUR, 1'b1, 8'h5A, 8'hC3, 4, 4);
        i_edge_sel <= 1'b1;
        t_words(OGB_MODE_EIGHT, 1'b0, 8'h96, 8'h01, 0, 8);
        t_stall();
        print_verdict();
    end
endmodule : ogb_gearbox_tb_top
